// File: shared/sdp_ram_pkg.sv
// Constants and carrier types for the simple dual-port block memory.
package sdp_ram_pkg;
    localparam int ADDR_W      = 14;
    localparam int DATA_W      = 32;
    localparam int PAR_W       = 4;
    localparam int WORD_W      = 40;
    localparam int MASK_W      = 4;
    localparam int DEPTH       = 512;
    localparam int IDX_W       = 9;
    localparam int ADDR_LSB    = 5;
    localparam logic [1:0] LAT_ONE = 2'h1;
    localparam logic [1:0] LAT_TWO = 2'h2;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [PAR_W-1:0]  par;
        logic [PAR_W-1:0]  parx;
    } bus_word_t;

    typedef struct packed {
        logic              en;
        logic [MASK_W-1:0] mask;
        logic [ADDR_W-1:0] addr;
        bus_word_t         word;
    } wr_req_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
    } rd_req_t;
endpackage : sdp_ram_pkg

// File: verification/sdp_fabric_drv.sv
// Fabric-side port driver that turns word indexes into request buses.
`timescale 1ns/100ps
`default_nettype none
module sdp_fabric_drv (
    input  wire logic [sdp_ram_pkg::IDX_W-1:0]  rdIdx,
    input  wire logic                           rdGo,
    input  wire logic [sdp_ram_pkg::IDX_W-1:0]  wrIdx,
    input  wire logic                           wrGo,
    input  wire logic [sdp_ram_pkg::MASK_W-1:0] mask,
    input  wire sdp_ram_pkg::bus_word_t         word,
    output var  sdp_ram_pkg::rd_req_t           rdReq,
    output var  sdp_ram_pkg::wr_req_t           wrReq
);
    import sdp_ram_pkg::*;
    // The depth is below the maximum, so a right-justified index would alias rows.
    always_comb begin
        rdReq.en   = rdGo;
        rdReq.addr = {rdIdx, {ADDR_LSB{1'b0}}};
        wrReq.en   = wrGo;
        wrReq.mask = mask;
        wrReq.addr = {wrIdx, {ADDR_LSB{1'b0}}};
        wrReq.word = word;
    end
endmodule : sdp_fabric_drv
`default_nettype wire

// File: verification/sdp_ram_tb_top.sv
// Self-checking bench for both read-timing options of the dual-port memory.
`timescale 1ns/100ps
`default_nettype none
module sdp_ram_tb_top;
    import sdp_ram_pkg::*;
    logic              sys_clk = 1'b0, sys_rst = 1'b1, rdGo = 1'b0, wrGo = 1'b0, useWord = 1'b0;
    logic [IDX_W-1:0]  rdIdx = '0, wrIdx = '0;
    logic [MASK_W-1:0] mask = '0;
    logic [WORD_W-1:0] wrWord = '0, rdWord [2];
    bus_word_t         busIn = '0, src, rdBus [2], pW [2], mem [DEPTH];
    rd_req_t           rdReq;
    wr_req_t           wrReq;
    logic              rdValid [2], rdCollide [2], pV [2] = '{0, 0}, pC [2];
    int                num_errors = 0, total_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    sdp_fabric_drv drv (.rdIdx(rdIdx), .rdGo(rdGo), .wrIdx(wrIdx), .wrGo(wrGo), .mask(mask),
        .word(busIn), .rdReq(rdReq), .wrReq(wrReq));
    for (genvar k = 0; k < 2; k++) begin : g_opt
        sdp_ram #(.OUT_REG(k == 1), .ECC_EN(1'b0)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
            .wrReq(wrReq), .rdReq(rdReq), .wrWord(wrWord), .useWord(useWord),
            .rdBus(rdBus[k]), .rdWord(rdWord[k]), .rdValid(rdValid[k]),
            .rdCollide(rdCollide[k]));
    end

    function automatic bus_word_t pack40(input logic [WORD_W-1:0] w);
        pack40.parx = {w[39], w[29], w[19], w[9]};
        pack40.par  = {w[34], w[24], w[14], w[4]};
        pack40.data = {w[38:35], w[33:30], w[28:25], w[23:20], w[18:15], w[13:10], w[8:5],
                       w[3:0]};
    endfunction : pack40

    task automatic cmp(input logic [WORD_W-1:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask : cmp

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic step(input logic wg, uw, rg, input logic [3:0] m, input int wi, ri);
        @(posedge sys_clk);
        wrGo <= wg;
        useWord <= uw;
        rdGo <= rg;
        mask <= m;
        wrIdx <= IDX_W'(wi);
        rdIdx <= IDX_W'(ri);
        wrWord <= WORD_W'({$urandom, $urandom});
        busIn <= WORD_W'({$urandom, $urandom});
    endtask : step

    assign src = useWord ? pack40(wrWord) : wrReq.word;

    // Expected read pipeline and memory contents, sampled on the taking edge.
    always @(posedge sys_clk) begin
        pV[1] <= pV[0];
        pC[1] <= pC[0];
        pW[1] <= pW[0];
        pV[0] <= rdReq.en && !sys_rst;
        pC[0] <= wrReq.en && (|wrReq.mask) && wrReq.addr == rdReq.addr;
        pW[0] <= mem[rdReq.addr[ADDR_W-1:ADDR_LSB]];
        if (wrReq.en && !sys_rst) for (int g = 0; g < MASK_W; g++) if (wrReq.mask[g]) begin
            mem[wrReq.addr[ADDR_W-1:ADDR_LSB]].data[8*g+:8] <= src.data[8*g+:8];
            mem[wrReq.addr[ADDR_W-1:ADDR_LSB]].par[g] <= src.par[g];
            mem[wrReq.addr[ADDR_W-1:ADDR_LSB]].parx[g] <= src.parx[g];
        end
    end

    always @(negedge sys_clk) if (!sys_rst) for (int k = 0; k < 2; k++) begin
        cmp(WORD_W'(rdValid[k]), WORD_W'(pV[k]), "valid");
        if (pV[k]) cmp(WORD_W'(rdCollide[k]), WORD_W'(pC[k]), "collide");
        if (pV[k] && !pC[k]) begin
            cmp(rdBus[k], pW[k], "bus");
            cmp(pack40(rdWord[k]), pW[k], "word");
        end
    end

    initial begin
        repeat (4000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end

    initial begin
        void'($urandom(32'h43156018));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < DEPTH; i++) step(1, 1, 0, 4'hf, i, 0);
        for (int i = 0; i < 2000; i++) step(1'($urandom), 1'($urandom), 1'($urandom),
            4'($urandom), $urandom % DEPTH, $urandom % DEPTH);
        step(1, 1, 1, 4'hf, 7, 7);
        step(1, 0, 1, 4'h5, 511, 511);
        step(0, 1, 1, 4'hf, 3, 7);
        step(0, 0, 1, 4'h0, 0, 511);
        step(0, 0, 1, 4'h0, 0, 3);
        repeat (3) step(0, 0, 0, 4'h0, 0, 0);
        test_done();
    end
endmodule : sdp_ram_tb_top
`default_nettype wire

// File: verilog/sdp_ram.sv
// Simple dual-port 512 x 40 block memory with latched or registered read port.
// Notes on behaviour
// R1: Three input buses and three output buses: primary data plus two parity buses.
// R2: With error correction on, parity pins are internal check bits; external ones unused.
// R3: 40-bit word: bits 39,29,19,9 on upper parity, 34,24,14,4 on lower.
// R4: 36-bit word: bits 35,26,17,8 on lower parity, bytes packed, upper parity unused.
// R5: 20-bit word: bits 19,9 and 14,4 in low parity bits, zero padded.
// R6: 18-bit word: bits 17,8 in low lower-parity bits, two bytes on primary.
// R7: 10-bit word: bit 9 upper, bit 4 lower parity; 9 and 5 bit use lower.
// R8: Power-of-two widths sit low on primary bus; parity buses unused.
// R9: Driving logic left-justifies addresses on the 14-bit buses for shallower depths.
// R10: Unused low address bits are zero; 512 deep uses bits 13:5.
// R11: Output register off: address registered, word latched next clock, one cycle latency.
// R12: Output register on: extra stage after latch, two cycles latency.
// R13: Reader presents address and read strobe at the same read-clock edge.
// R14: Word appears on all three output buses one or two cycles after request.
// R15: Write only when port enable and byte mask bits are both set.
// R16: Same-cycle write and read of one location: write wins, read data invalid.
`timescale 1ns/100ps
`default_nettype none
module sdp_ram #(
    parameter bit OUT_REG = 1'b0,
    parameter bit ECC_EN  = 1'b0
) (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire sdp_ram_pkg::wr_req_t  wrReq,
    input  wire sdp_ram_pkg::rd_req_t  rdReq,
    input  wire logic [sdp_ram_pkg::WORD_W-1:0] wrWord,
    input  wire logic                  useWord,
    output var  sdp_ram_pkg::bus_word_t rdBus,
    output var  logic [sdp_ram_pkg::WORD_W-1:0] rdWord,
    output var  logic                  rdValid,
    output var  logic                  rdCollide
);
    import sdp_ram_pkg::*;

    // Storage holds bus-layout words so every width mapping shares one array.
    bus_word_t            mem_q [DEPTH];
    bus_word_t            packedIn;
    bus_word_t            wrBus;
    bus_word_t            latch_q, latch_d;
    bus_word_t            outReg_q, outReg_d;
    bus_word_t            rdBusView;
    logic [WORD_W-1:0]    rdWordView;
    logic [WORD_W-1:0]    rdWord_q;
    logic                 v1_q, v1_d, v2_q, v2_d;
    logic                 c1_q, c1_d, c2_q, c2_d;
    logic [IDX_W-1:0]     wrIdx, rdIdx;
    logic                 collide;
    logic [MASK_W-1:0]    laneWe;

    sdp_word_pack u_pack (
        .word    (wrWord),
        .busWord (packedIn)
    );

    // Narrower widths are packed by the caller onto the raw buses before the write.
    always_comb begin
        wrBus = useWord ? packedIn : wrReq.word; // R1 R4 R5 R6 R7 R8
        if (ECC_EN) begin
            // Check bits are not modelled; external parity is ignored and reads as zero.
            wrBus.par  = '0; // R2
            wrBus.parx = '0; // R2
        end
        wrIdx  = wrReq.addr[ADDR_W-1:ADDR_LSB]; // R9 R10
        rdIdx  = rdReq.addr[ADDR_W-1:ADDR_LSB]; // R9 R10
        laneWe = wrReq.en ? wrReq.mask : '0; // R15
        collide = rdReq.en && (laneWe != '0) && (wrIdx == rdIdx); // R16
    end

    // Each byte lane carries one byte of primary data and its matching parity bits.
    // One process writes all lanes, since a variable index would give the array many drivers.
    always_ff @(posedge sys_clk) begin
        for (int g = 0; g < MASK_W; g++) begin
            if (laneWe[g]) begin // R15
                mem_q[wrIdx].data[8*g +: 8] <= wrBus.data[8*g +: 8];
                mem_q[wrIdx].par[g]         <= wrBus.par[g];
                mem_q[wrIdx].parx[g]        <= wrBus.parx[g];
            end
        end
    end

    always_comb begin
        latch_d  = latch_q;
        outReg_d = outReg_q;
        v1_d     = rdReq.en; // R13
        c1_d     = rdReq.en && collide;
        v2_d     = v1_q;
        c2_d     = c1_q;
        if (rdReq.en) begin
            latch_d = mem_q[rdIdx]; // R11
        end
        if (v1_q) begin
            outReg_d = latch_q; // R12
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            latch_q  <= '0;
            outReg_q <= '0;
            v1_q     <= 1'b0;
            v2_q     <= 1'b0;
            c1_q     <= 1'b0;
            c2_q     <= 1'b0;
        end else begin
            latch_q  <= latch_d;
            outReg_q <= outReg_d;
            v1_q     <= v1_d;
            v2_q     <= v2_d;
            c1_q     <= c1_d;
            c2_q     <= c2_d;
        end
    end

    // The registered stage trades one cycle of latency for a shorter output path.
    always_comb begin
        rdBusView = OUT_REG ? outReg_q : latch_q; // R14
        if (ECC_EN) begin
            rdBusView.par  = '0; // R2
            rdBusView.parx = '0; // R2
        end
        rdValid   = OUT_REG ? v2_q : v1_q; // R14
        rdCollide = OUT_REG ? c2_q : c1_q; // R16
        rdBus     = rdBusView;
        rdWord    = rdWord_q;
    end

    sdp_word_unpack u_unpack (
        .busWord (rdBusView),
        .word    (rdWordView)
    );

    always_comb begin
        rdWord_q = rdWordView;
    end

    a_latch_lat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !OUT_REG && rdReq.en |=> rdValid) else $error("read not valid after one cycle"); // R11
    a_reg_lat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        OUT_REG && rdReq.en |=> ##1 rdValid) else $error("read not valid after two cycles"); // R12
    a_no_spurious: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !OUT_REG && !rdReq.en |=> !rdValid) else $error("valid without request"); // R14
    a_read_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !OUT_REG && !ECC_EN && rdReq.en && !collide |=> rdBus == $past(mem_q[rdIdx]))
        else $error("read data mismatch"); // R14
    a_hold_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !OUT_REG && !rdReq.en |=> $stable(rdBus)) else $error("output not held"); // R11
    a_collide_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !OUT_REG && collide |=> rdCollide) else $error("collision not flagged"); // R16
    a_write_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !wrReq.en |-> laneWe == '0) else $error("write without enable"); // R15
    a_ecc_par: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ECC_EN |-> rdBus.par == '0 && rdBus.parx == '0) else $error("parity out used"); // R2

    c_read: cover property (@(posedge sys_clk) disable iff (sys_rst) rdReq.en ##1 rdValid);
    c_write: cover property (@(posedge sys_clk) disable iff (sys_rst) laneWe != '0);
    c_collide: cover property (@(posedge sys_clk) disable iff (sys_rst) collide);
    c_back_to_back: cover property (@(posedge sys_clk) disable iff (sys_rst)
        rdReq.en ##1 rdReq.en ##1 rdValid);
endmodule : sdp_ram
`default_nettype wire

// File: verilog/sdp_word_pack.sv
// Packs a 40-bit logical word onto the primary and two parity buses.
`timescale 1ns/100ps
`default_nettype none
module sdp_word_pack (
    input  wire logic [sdp_ram_pkg::WORD_W-1:0] word,
    output var  sdp_ram_pkg::bus_word_t         busWord
);
    import sdp_ram_pkg::*;
    always_comb begin
        busWord.parx = {word[39], word[29], word[19], word[9]}; // R3
        busWord.par  = {word[34], word[24], word[14], word[4]}; // R3
        busWord.data = {word[38:35], word[33:30], word[28:25], word[23:20],
                       word[18:15], word[13:10], word[8:5], word[3:0]}; // R3
    end
endmodule : sdp_word_pack
`default_nettype wire

// File: verilog/sdp_word_unpack.sv
// Rebuilds a 40-bit logical word from the primary and two parity buses.
`timescale 1ns/100ps
`default_nettype none
module sdp_word_unpack (
    input  wire sdp_ram_pkg::bus_word_t         busWord,
    output var  logic [sdp_ram_pkg::WORD_W-1:0] word
);
    import sdp_ram_pkg::*;
    always_comb begin
        word = {busWord.parx[3], busWord.data[31:28], busWord.par[3], busWord.data[27:24],
                busWord.parx[2], busWord.data[23:20], busWord.par[2], busWord.data[19:16],
                busWord.parx[1], busWord.data[15:12], busWord.par[1], busWord.data[11:8],
                busWord.parx[0], busWord.data[7:4],   busWord.par[0], busWord.data[3:0]}; // R3
    end
endmodule : sdp_word_unpack
`default_nettype wire
